//--- core/ppmc_consts.vh
// Constants shared by the power-management and message-interrupt logic.
`ifndef PPMC_CONSTS_VH
`define PPMC_CONSTS_VH

// Power-management control and status word, byte offset from its pointer.
`define PPMC_POWER_MGMT_CONTROL_STATUS_OFS      8'h04
// Message interrupt capability, byte offsets from its pointer.
`define PPMC_MID_OFS       8'h00
`define PPMC_MA_OFS        8'h04
`define PPMC_MUA_OFS       8'h08
`define PPMC_MD_NARROW_OFS 8'h08
`define PPMC_MD_WIDE_OFS   8'h0c

// Field positions of the power-management control and status word.
`define PPMC_WES_BIT       15
`define PPMC_WEE_BIT       8
`define PPMC_PS_HI         1
`define PPMC_PS_LO         0

// Power state encodings.
`define PPMC_PS_D0         2'h0
`define PPMC_PS_D3HOT      2'h3

// Capability code of the message interrupt capability.
`define PPMC_MSI_CAP_CODE  8'h05

// Field positions of the message control word.
`define PPMC_C64_BIT       7
`define PPMC_MME_HI        6
`define PPMC_MME_LO        4
`define PPMC_MMC_HI        3
`define PPMC_MMC_LO        1
`define PPMC_MESSAGE_INTERRUPT_ENABLE_BIT      0

// Reset values.
`define PPMC_MME_RST       3'h0
`define PPMC_PS_RST        2'h0
`define PPMC_ADDR_RST      30'h0
`define PPMC_UADDR_RST     32'h0
`define PPMC_DATA_RST      16'h0
`define PPMC_WORD_ZERO     32'h0
`define PPMC_HALF_ZERO     16'h0

`endif

//--- core/ppmc_sync.v
// Three-stage synchroniser that accepts a change once stages two and three agree.
module ppmc_sync (
	input  wire clk_i,   // Bus clock.
	input  wire rst_i,   // Asynchronous reset, active high.
	input  wire async_i, // Level from outside the clock domain.
	output reg  sync_o   // Filtered level in the clock domain.
);

	reg s1_ff; // First stage, read only by the second stage.
	reg s2_ff; // Second stage.
	reg s3_ff; // Third stage.

	// Shift the level in and update the output when stages two and three agree.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_ff  <= 1'b0;
			s2_ff  <= 1'b0;
			s3_ff  <= 1'b0;
			sync_o <= 1'b0;
		end else begin
			s1_ff <= async_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				sync_o <= s3_ff;
			end
		end
	end

endmodule

//--- core/ppmc_cap.v
// Power-management control word and message interrupt capability registers.
//
// Operation
// - Wake event sets status; software writes one.
// - Wake bits cleared by bus reset unless cold wake.
// - Enable set drives wake pin while status.
// - Control bits 14:09 read zero, ignore writes.
// - Power state resets D0, reads current state.
// - Only D0 and D3hot encodings accepted.
// - D3hot keeps config, blocks memory spaces.
// - D3hot suppresses message and legacy interrupts.
// - Identifier low byte reads capability code 05h.
// - Identifier high byte is fixed next pointer.
// - Control bit 07 reports wide address capability.
// - Allowed message count resets zero, writable.
// - Requested message count field is fixed.
// - Enable bit selects messages over legacy pins.
// - Data register at offset 8 or C.
// - Upper address at offset 8 when wide.
// - Lower address bits 1:0 read zero.
// - Data value drives low message data word.
`include "ppmc_consts.vh"

module ppmc_cap #(
	parameter [7:0] PM_CAP_PTR  = 8'h40, // Power-management capability pointer.
	parameter [7:0] MSI_CAP_PTR = 8'h50, // Message capability pointer.
	parameter [7:0] MSI_NEXT    = 8'h00, // Next capability pointer, 0 = end.
	parameter       WIDE_ADDR   = 1'b1,  // Wide message address capable.
	parameter [2:0] REQ_COUNT   = 3'h0,  // Requested message count field.
	parameter       COLD_WAKE   = 1'b0   // Waking from D3cold supported.
) (
	input  wire        clk_i,       // Bus clock, 100 MHz.
	input  wire        rst_i,       // Bus reset, asynchronous, active high.
	input  wire        pwr_rst_i,   // Auxiliary power-on reset, active high.
	input  wire        cfg_req_i,   // Configuration access request.
	input  wire        cfg_we_i,    // Access is a write.
	input  wire [7:0]  cfg_addr_i,  // Configuration byte address.
	input  wire [3:0]  cfg_be_i,    // Byte enables of the write.
	input  wire [31:0] cfg_wdata_i, // Write data.
	output reg  [31:0] cfg_rdata_o, // Read data.
	output reg         cfg_ack_o,   // Access done, one-cycle pulse.
	output reg         cfg_hit_o,   // Access fell on one of our words.
	input  wire        wake_pin_i,  // Asynchronous wake event source.
	output reg         pme_out_o,   // Wake pin output level, always low.
	output reg         pme_oe_o,    // Wake pin drive enable.
	output reg         mem_en_o,    // Memory register spaces may answer.
	input  wire        intr_i,      // Interrupt pending level, same clock.
	output reg         intx_o,      // Legacy interrupt request level.
	output reg         msi_wr_o,    // Message write request pulse.
	output reg  [63:0] msi_addr_o,  // Message write address.
	output reg  [31:0] msi_data_o   // Message write data.
);

	// Word addresses of the implemented configuration dwords.
	localparam [7:0] POWER_MGMT_CONTROL_STATUS_A = PM_CAP_PTR + `PPMC_POWER_MGMT_CONTROL_STATUS_OFS;
	localparam [7:0] MID_A  = MSI_CAP_PTR + `PPMC_MID_OFS;
	localparam [7:0] MA_A   = MSI_CAP_PTR + `PPMC_MA_OFS;
	localparam [7:0] MUA_A  = MSI_CAP_PTR + `PPMC_MUA_OFS;
	localparam [7:0] MD_A   = WIDE_ADDR ?
		MSI_CAP_PTR + `PPMC_MD_WIDE_OFS :
		MSI_CAP_PTR + `PPMC_MD_NARROW_OFS;

	reg [1:0]  ps_ff;     // Current power state.
	reg        wes_ff;    // Wake event status.
	reg        wee_ff;    // Wake event enable.
	reg [2:0]  mme_ff;    // Allowed message count.
	reg        message_interrupt_enable_ff;   // Message interrupt enable.
	reg [29:0] addr_ff;   // Lower message address, bits 31:02.
	reg [31:0] uaddr_ff;  // Upper message address.
	reg [15:0] data_ff;   // Message data value.
	reg        intr_d_ff; // Interrupt level of the previous cycle.
	reg        wake_d_ff; // Synchronised wake level of the previous cycle.

	wire       wake_sync; // Synchronised wake source.
	wire       wake_rst;  // Reset of the wake bits.
	wire       wr;        // Write strobe of this cycle.
	wire [15:0] mc_word;  // Message control word as read.
	wire [15:0] power_mgmt_control_status_word; // Power-management control word as read.
	wire       d0;        // Device is in D0.

	// Word match on the dword part of the address, used for every register.
	function hit;
		input [7:0] addr;
		input [7:0] base;
		begin
			hit = (addr[7:2] == base[7:2]);
		end
	endfunction

	// Bring the wake source into the clock domain.
	ppmc_sync u_wake_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (wake_pin_i),
		.sync_o  (wake_sync)
	);

	// With cold wake the bits survive bus reset; only power-on clears them.
	assign wake_rst = COLD_WAKE ? pwr_rst_i : (rst_i | pwr_rst_i);

	assign wr = cfg_req_i & cfg_we_i;
	assign d0 = (ps_ff == `PPMC_PS_D0);

	// Control word reads; bits 14:09 and 07:02 read as zero.
	assign power_mgmt_control_status_word = {wes_ff, 6'h00, wee_ff, 6'h00, ps_ff};

	// Message control word; capability and requested count fields are fixed.
	assign mc_word = {8'h00, WIDE_ADDR[0], mme_ff, REQ_COUNT,
		message_interrupt_enable_ff};

	// Wake status and enable bits, with their own reset.
	always @(posedge clk_i or posedge wake_rst) begin
		if (wake_rst) begin
			wes_ff <= 1'b0;
			wee_ff <= 1'b0;
		end else begin
			// A new event wins over a write-one clear in the same cycle.
			if (wake_sync & ~wake_d_ff) begin
				wes_ff <= 1'b1;
			end else if (wr & hit(cfg_addr_i, POWER_MGMT_CONTROL_STATUS_A) & cfg_be_i[1] &
				cfg_wdata_i[`PPMC_WES_BIT]) begin
				wes_ff <= 1'b0;
			end
			if (wr & hit(cfg_addr_i, POWER_MGMT_CONTROL_STATUS_A) & cfg_be_i[1]) begin
				wee_ff <= cfg_wdata_i[`PPMC_WEE_BIT];
			end
		end
	end

	// Power state and message capability registers under bus reset.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ps_ff    <= `PPMC_PS_RST;
			mme_ff   <= `PPMC_MME_RST;
			message_interrupt_enable_ff  <= 1'b0;
			addr_ff  <= `PPMC_ADDR_RST;
			uaddr_ff <= `PPMC_UADDR_RST;
			data_ff  <= `PPMC_DATA_RST;
		end else if (wr) begin
			// Power state: only D0 and D3hot codes are taken.
			if (hit(cfg_addr_i, POWER_MGMT_CONTROL_STATUS_A) & cfg_be_i[0]) begin
				case (cfg_wdata_i[`PPMC_PS_HI:`PPMC_PS_LO])
				`PPMC_PS_D0: begin
					ps_ff <= `PPMC_PS_D0;
				end
				`PPMC_PS_D3HOT: begin
					ps_ff <= `PPMC_PS_D3HOT;
				end
				default: begin
					ps_ff <= ps_ff;
				end
				endcase
			end
			// Message control sits in the upper half of the identifier dword.
			if (hit(cfg_addr_i, MID_A) & cfg_be_i[2]) begin
				mme_ff <= cfg_wdata_i[`PPMC_MME_HI + 16:
					`PPMC_MME_LO + 16];
				message_interrupt_enable_ff <= cfg_wdata_i[`PPMC_MESSAGE_INTERRUPT_ENABLE_BIT + 16];
			end
			// Lower address keeps only bits 31:02.
			if (hit(cfg_addr_i, MA_A)) begin
				if (cfg_be_i[0]) begin
					addr_ff[5:0] <= cfg_wdata_i[7:2];
				end
				if (cfg_be_i[1]) begin
					addr_ff[13:6] <= cfg_wdata_i[15:8];
				end
				if (cfg_be_i[2]) begin
					addr_ff[21:14] <= cfg_wdata_i[23:16];
				end
				if (cfg_be_i[3]) begin
					addr_ff[29:22] <= cfg_wdata_i[31:24];
				end
			end
			// Upper address exists only with wide addressing.
			if (WIDE_ADDR && hit(cfg_addr_i, MUA_A)) begin
				if (cfg_be_i[0]) begin
					uaddr_ff[7:0] <= cfg_wdata_i[7:0];
				end
				if (cfg_be_i[1]) begin
					uaddr_ff[15:8] <= cfg_wdata_i[15:8];
				end
				if (cfg_be_i[2]) begin
					uaddr_ff[23:16] <= cfg_wdata_i[23:16];
				end
				if (cfg_be_i[3]) begin
					uaddr_ff[31:24] <= cfg_wdata_i[31:24];
				end
			end
			// Message data value, low half of its dword.
			if (hit(cfg_addr_i, MD_A)) begin
				if (cfg_be_i[0]) begin
					data_ff[7:0] <= cfg_wdata_i[7:0];
				end
				if (cfg_be_i[1]) begin
					data_ff[15:8] <= cfg_wdata_i[15:8];
				end
			end
		end
	end

	// Configuration answer: one cycle after the request, also in D3hot.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_ack_o   <= 1'b0;
			cfg_hit_o   <= 1'b0;
			cfg_rdata_o <= `PPMC_WORD_ZERO;
		end else begin
			cfg_ack_o <= cfg_req_i;
			cfg_hit_o <= 1'b0;
			cfg_rdata_o <= `PPMC_WORD_ZERO;
			if (cfg_req_i) begin
				if (hit(cfg_addr_i, POWER_MGMT_CONTROL_STATUS_A)) begin
					cfg_hit_o   <= 1'b1;
					cfg_rdata_o <= {`PPMC_HALF_ZERO, power_mgmt_control_status_word};
				end else if (hit(cfg_addr_i, MID_A)) begin
					cfg_hit_o   <= 1'b1;
					cfg_rdata_o <= {mc_word, MSI_NEXT,
						`PPMC_MSI_CAP_CODE};
				end else if (hit(cfg_addr_i, MA_A)) begin
					cfg_hit_o   <= 1'b1;
					cfg_rdata_o <= {addr_ff, 2'h0};
				end else if (WIDE_ADDR && hit(cfg_addr_i, MUA_A)) begin
					cfg_hit_o   <= 1'b1;
					cfg_rdata_o <= uaddr_ff;
				end else if (hit(cfg_addr_i, MD_A)) begin
					cfg_hit_o   <= 1'b1;
					cfg_rdata_o <= {`PPMC_HALF_ZERO, data_ff};
				end
			end
		end
	end

	// Wake pin, memory gating and interrupt delivery.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_d_ff  <= 1'b0;
			intr_d_ff  <= 1'b0;
			pme_out_o  <= 1'b0;
			pme_oe_o   <= 1'b0;
			mem_en_o   <= 1'b1;
			intx_o     <= 1'b0;
			msi_wr_o   <= 1'b0;
			msi_addr_o <= 64'h0;
			msi_data_o <= `PPMC_WORD_ZERO;
		end else begin
			wake_d_ff <= wake_sync;
			pme_out_o <= 1'b0;
			// Open-drain wake pin pulled low while enabled status stands.
			pme_oe_o  <= wee_ff & wes_ff;
			mem_en_o  <= d0;
			// Legacy pin only when messages are off and in D0.
			intx_o    <= intr_i & ~message_interrupt_enable_ff & d0;
			// Arm on each new pending edge; D3hot swallows it.
			intr_d_ff <= intr_i;
			msi_wr_o  <= intr_i & ~intr_d_ff & message_interrupt_enable_ff & d0;
			msi_addr_o <= {WIDE_ADDR ? uaddr_ff : `PPMC_UADDR_RST,
				addr_ff, 2'h0};
			msi_data_o <= {`PPMC_HALF_ZERO, data_ff};
		end
	end

	// Counts above the capable field are the software side's concern.

endmodule

//--- tb/ppmc_cap_assertions.sv
// Port-level checker of the capability register block.
module ppmc_cap_assertions #(
	parameter [7:0] PM_CAP_PTR  = 8'h40, // Power capability pointer.
	parameter [7:0] MSI_CAP_PTR = 8'h50, // Message capability pointer.
	parameter [7:0] MSI_NEXT    = 8'h00, // Next capability pointer.
	parameter       WIDE_ADDR   = 1'b1,  // Wide address capable.
	parameter [2:0] REQ_COUNT   = 3'h0   // Requested message count.
) (
	input wire        clk_i, rst_i, pwr_rst_i, cfg_req_i, cfg_we_i, // Controls.
	input wire [7:0]  cfg_addr_i,          // Access address.
	input wire [3:0]  cfg_be_i,            // Byte enables.
	input wire [31:0] cfg_wdata_i,         // Write data.
	input wire [31:0] cfg_rdata_o,         // Read data.
	input wire        cfg_ack_o, cfg_hit_o, // Access answer.
	input wire        wake_pin_i, pme_out_o, pme_oe_o, mem_en_o, // Wake.
	input wire        intr_i, intx_o, msi_wr_o, // Interrupts.
	input wire [63:0] msi_addr_o,          // Message address.
	input wire [31:0] msi_data_o           // Message data.
);
	// One clock domain, so one clocking and one disable serve all.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Dword select of the power word and of the identifier word.
	wire [5:0] pm_dw = PM_CAP_PTR[7:2] + 6'h1;
	wire [5:0] id_dw = MSI_CAP_PTR[7:2];
	property p_ack; cfg_req_i |=> cfg_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("no answer to access");
	property p_idle; !cfg_req_i |=> !cfg_ack_o; endproperty
	a_idle: assert property (p_idle) else $error("answer without access");
	property p_pm_rsvd;
		cfg_ack_o && $past(!cfg_we_i && cfg_addr_i[7:2] == pm_dw)
		|-> (cfg_rdata_o & 32'hffff7efc) == 32'h0
		&& cfg_rdata_o[1] == cfg_rdata_o[0];
	endproperty
	a_pm_rsvd: assert property (p_pm_rsvd) else $error("bad power word");
	property p_msi_id;
		cfg_ack_o && $past(!cfg_we_i && cfg_addr_i[7:2] == id_dw)
		|-> cfg_rdata_o[15:0] == {MSI_NEXT, 8'h05} && cfg_rdata_o[23] == WIDE_ADDR
		&& cfg_rdata_o[19:17] == REQ_COUNT && cfg_rdata_o[31:24] == 8'h0;
	endproperty
	a_msi_id: assert property (p_msi_id) else $error("bad identifier");
	property p_align; msi_addr_o[1:0] == 2'h0; endproperty
	a_align: assert property (p_align) else $error("unaligned address");
	property p_data_hi; msi_data_o[31:16] == 16'h0; endproperty
	a_data_hi: assert property (p_data_hi) else $error("data upper half");
	property p_msi_edge;
		msi_wr_o |-> $past(intr_i) && !$past(intr_i, 2) && mem_en_o;
	endproperty
	a_msi_edge: assert property (p_msi_edge) else $error("stray message");
	property p_intx; intx_o |-> $past(intr_i) && mem_en_o && !msi_wr_o; endproperty
	a_intx: assert property (p_intx) else $error("stray legacy level");
	property p_d3;
		cfg_req_i && cfg_we_i && cfg_be_i[0] && cfg_addr_i[7:2] == pm_dw
		&& cfg_wdata_i[1:0] == 2'h3 |=> ##1 !mem_en_o;
	endproperty
	a_d3: assert property (p_d3) else $error("memory open in D3hot");
	property p_pme_off;
		cfg_req_i && cfg_we_i && cfg_be_i[1] && cfg_addr_i[7:2] == pm_dw
		&& !cfg_wdata_i[8] |=> ##1 !pme_oe_o;
	endproperty
	a_pme_off: assert property (p_pme_off) else $error("wake drive stuck");
endmodule

bind ppmc_cap ppmc_cap_assertions #(.PM_CAP_PTR(PM_CAP_PTR),
	.MSI_CAP_PTR(MSI_CAP_PTR), .MSI_NEXT(MSI_NEXT), .WIDE_ADDR(WIDE_ADDR),
	.REQ_COUNT(REQ_COUNT)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.pwr_rst_i(pwr_rst_i), .cfg_req_i(cfg_req_i), .cfg_we_i(cfg_we_i),
	.cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
	.cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o), .cfg_hit_o(cfg_hit_o),
	.wake_pin_i(wake_pin_i), .pme_out_o(pme_out_o), .pme_oe_o(pme_oe_o),
	.mem_en_o(mem_en_o), .intr_i(intr_i), .intx_o(intx_o),
	.msi_wr_o(msi_wr_o), .msi_addr_o(msi_addr_o), .msi_data_o(msi_data_o));

//--- tb/ppmc_host.sv
// Host bridge model that accepts message writes and keeps the last one.
module ppmc_host (
	input  wire        clk_i,   // Bus clock.
	input  wire        rst_i,   // Bus reset, active high.
	input  wire        wr_i,    // Message write request.
	input  wire [63:0] addr_i,  // Message address.
	input  wire [31:0] data_i,  // Message data.
	output reg  [7:0]  count_o, // Number of writes taken.
	output reg  [63:0] addr_o,  // Address of the last write.
	output reg  [31:0] data_o   // Data of the last write.
);
	timeunit 1ns;
	timeprecision 1ps;
	// Every request cycle is one whole memory write, taken at once.
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			count_o <= 8'h0;
			addr_o  <= 64'h0;
			data_o  <= 32'h0;
		end else if (wr_i) begin
			count_o <= count_o + 8'h1;
			addr_o  <= addr_i;
			data_o  <= data_i;
		end
	end
endmodule

//--- tb/test_pci_pm_msi_capability.sv
// Self-checking bench of the capability register block.
module test_pci_pm_msi_capability;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [7:0] PM = 8'h44; // Power word address.
	localparam [7:0] MS = 8'h50; // Message capability address.
	reg        clk_i = 0, rst_i = 1, pwr_rst_i = 1, wake_pin_i = 0, intr_i = 0;
	reg        cfg_req_i = 0, cfg_we_i = 0;                 // Access controls.
	reg [7:0]  cfg_addr_i = 0;                              // Access address.
	reg [3:0]  cfg_be_i = 0;                                // Byte enables.
	reg [31:0] cfg_wdata_i = 0, rd, lo, hi, dat;            // Data values.
	reg [2:0]  allowed_message_count;                                         // Allowed count.
	reg [7:0]  n0;                                          // Writes seen before.
	reg        hv;                                          // Hit flag taken.
	wire [31:0] cfg_rdata_o, msi_data_o, h_data;            // Data outputs.
	wire [63:0] msi_addr_o, h_addr;                         // Addresses.
	wire [7:0]  n_msg;                                      // Writes taken.
	wire cfg_ack_o, cfg_hit_o, pme_out_o, pme_oe_o, mem_en_o, intx_o, msi_wr_o;
	integer err_count = 0, check_count = 0, i;
	always #5 clk_i = ~clk_i;
	ppmc_cap #(.REQ_COUNT(3'h3)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.pwr_rst_i(pwr_rst_i), .cfg_req_i(cfg_req_i), .cfg_we_i(cfg_we_i),
		.cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i),
		.cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o), .cfg_hit_o(cfg_hit_o),
		.wake_pin_i(wake_pin_i), .pme_out_o(pme_out_o), .pme_oe_o(pme_oe_o),
		.mem_en_o(mem_en_o), .intr_i(intr_i), .intx_o(intx_o),
		.msi_wr_o(msi_wr_o), .msi_addr_o(msi_addr_o), .msi_data_o(msi_data_o));
	ppmc_host u_host (.clk_i(clk_i), .rst_i(rst_i), .wr_i(msi_wr_o),
		.addr_i(msi_addr_o), .data_i(msi_data_o), .count_o(n_msg),
		.addr_o(h_addr), .data_o(h_data));
	// Expected power word from status, enable and state.
	function [31:0] pm_exp(input s, input en, input [1:0] st);
		pm_exp = {16'h0, s, 6'h0, en, 6'h0, st};
	endfunction
	// Expected identifier and control word at the capability pointer.
	function [31:0] id_exp(input [2:0] m, input en);
		id_exp = {8'h0, 1'b1, m, 3'h3, en, 16'h0005};
	endfunction
	task chk(input [63:0] got, input [63:0] exp); begin
		check_count = check_count + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	end endtask
	// One access: request for one cycle; the answer stands in the next cycle.
	task cfg(input w, input [7:0] a, input [3:0] b, input [31:0] d); begin
		@(negedge clk_i);
		cfg_req_i = 1;
		cfg_we_i = w;
		cfg_addr_i = a;
		cfg_be_i = b;
		cfg_wdata_i = d;
		@(negedge clk_i);
		rd = cfg_rdata_o;
		hv = cfg_hit_o;
		chk(cfg_ack_o, 1'b1);
		cfg_req_i = 0;
	end endtask
	task rc(input [7:0] a, input [31:0] e, input h); begin
		cfg(0, a, 4'h0, 32'h0);
		chk(rd, e);
		chk(hv, h);
	end endtask
	// A rising interrupt edge held for a few cycles.
	task irq; begin
		n0 = n_msg;
		@(negedge clk_i);
		intr_i = 1;
		repeat (4) @(negedge clk_i);
		intr_i = 0;
		@(negedge clk_i);
	end endtask
	task conclude; begin
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end endtask
	// Watchdog far beyond the expected run length.
	initial begin
		#100000;
		err_count = err_count + 1;
		conclude;
	end
	// Main sequence.
	initial begin
		rd = $urandom(38982);
		repeat (4) @(negedge clk_i);
		rst_i = 0;
		pwr_rst_i = 0;
		chk(mem_en_o, 1'b1);
		rc(PM, pm_exp(0, 0, 2'h0), 1);
		rc(MS, id_exp(3'h0, 0), 1);
		cfg(1, PM, 4'hf, 32'hffff_fffd);
		rc(PM, pm_exp(0, 1, 2'h0), 1);
		cfg(1, PM, 4'h1, 32'h2);
		rc(PM, pm_exp(0, 1, 2'h0), 1);
		cfg(1, PM, 4'h1, 32'h3);
		rc(PM, pm_exp(0, 1, 2'h3), 1);
		chk(mem_en_o, 1'b0);
		cfg(1, MS, 4'h4, 32'h0001_0000);
		irq;
		chk(n_msg, n0);
		cfg(1, PM, 4'h1, 32'h0);
		wake_pin_i = 1;
		repeat (10) @(negedge clk_i);
		rc(PM, pm_exp(1, 1, 2'h0), 1);
		chk(pme_oe_o, 1'b1);
		chk(pme_out_o, 1'b0);
		wake_pin_i = 0;
		cfg(1, PM, 4'h2, 32'h8100);
		repeat (2) @(negedge clk_i);
		chk(pme_oe_o, 1'b0);
		rc(PM, pm_exp(0, 1, 2'h0), 1);
		pwr_rst_i = 1;
		@(negedge clk_i);
		pwr_rst_i = 0;
		rc(PM, pm_exp(0, 0, 2'h0), 1);
		lo = $urandom;
		hi = $urandom;
		dat = $urandom;
		allowed_message_count = $urandom % 4;
		cfg(1, MS + 8'h4, 4'hf, lo);
		cfg(1, MS + 8'h8, 4'hf, hi);
		cfg(1, MS + 8'hc, 4'hf, dat);
		rc(MS + 8'h4, lo & 32'hffff_fffc, 1);
		rc(MS + 8'h8, hi, 1);
		rc(MS + 8'hc, {16'h0, dat[15:0]}, 1);
		rc(MS + 8'h10, 32'h0, 0);
		cfg(1, MS, 4'hf, {8'hff, 1'b0, allowed_message_count, 3'h0, 1'b1, 16'hffff});
		rc(MS, id_exp(allowed_message_count, 1), 1);
		for (i = 0; i < 2; i = i + 1) begin
			irq;
			chk(n_msg, n0 + 8'h1);
			chk(h_addr, {hi, lo[31:2], 2'h0});
			chk(h_data, {16'h0, dat[15:0]});
		end
		cfg(1, MS, 4'h4, 32'h0);
		n0 = n_msg;
		@(negedge clk_i);
		intr_i = 1;
		repeat (2) @(negedge clk_i);
		chk(intx_o, 1'b1);
		intr_i = 0;
		repeat (2) @(negedge clk_i);
		chk(n_msg, n0);
		conclude;
	end
endmodule
